// [core/gsh_pkg.sv]
// Constants and types for the generic strobe host port controller
package gsh_pkg;
  localparam int          ADDR_W         = 17;
  localparam int          DATA_W         = 16;
  localparam logic [16:0] WIN_BYTES_M1   = 17'h1ffff;
  localparam logic [16:0] BUF_LIMIT      = 17'h14000;
  localparam logic [16:0] REG_BASE       = 17'h1ffe0;
  // AXI register offsets
  localparam logic [7:0]  OFF_CTRL       = 8'h00;
  localparam logic [7:0]  OFF_ADDR       = 8'h04;
  localparam logic [7:0]  OFF_WDATA      = 8'h08;
  localparam logic [7:0]  OFF_RDATA      = 8'h0c;
  localparam logic [7:0]  OFF_STATUS     = 8'h10;
  localparam logic [7:0]  OFF_STRAP      = 8'h14;
  // CTRL fields
  localparam int          CTRL_GO        = 0;
  localparam int          CTRL_WRITE     = 1;
  localparam int          CTRL_LANE_LO   = 2;
  localparam int          CTRL_LANE_HI   = 3;
  localparam int          CTRL_RESET     = 4;
  // Strap defaults: generic mode, little endian
  localparam logic [2:0]  MODE_GENERIC   = 3'h7;
  localparam logic        PHASE_GENERIC  = 1'b0;
  localparam logic        ORDER_RST      = 1'b0;
  localparam int          SETUP_CYC      = 2;
  localparam int          HOLD_CYC       = 2;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  typedef enum logic [2:0] {
    GSH_IDLE  = 3'b000,
    GSH_SETUP = 3'b001,
    GSH_WAIT  = 3'b010,
    GSH_HOLD  = 3'b011,
    GSH_RST   = 3'b100
  } gsh_state_e;
endpackage : gsh_pkg

// [core/gsh_host.sv]
// Host-side controller driving the generic strobe port from AXI4-Lite commands
`timescale 1ns/10ps
`default_nettype none
module gsh_host (
  input  wire logic                      clk_i,
  input  wire logic                      reset_n_i,
  input  wire logic [7:0]                s_awaddr_i,
  input  wire logic                      s_awvalid_i,
  output logic                           s_awready_o,
  input  wire logic [31:0]               s_wdata_i,
  input  wire logic [3:0]                s_wstrb_i,
  input  wire logic                      s_wvalid_i,
  output logic                           s_wready_o,
  output logic [1:0]                     s_bresp_o,
  output logic                           s_bvalid_o,
  input  wire logic                      s_bready_i,
  input  wire logic [7:0]                s_araddr_i,
  input  wire logic                      s_arvalid_i,
  output logic                           s_arready_o,
  output logic [31:0]                    s_rdata_o,
  output logic [1:0]                     s_rresp_o,
  output logic                           s_rvalid_o,
  input  wire logic                      s_rready_i,
  output logic                           dev_reset_n_o,
  output logic                           mode_strap_bit0_o,
  output logic                           mode_strap_bit1_o,
  output logic                           mode_strap_bit2_o,
  output logic                           byte_order_strap_o,
  output logic                           bus_phase_strap_n_o,
  output logic                           host_side_clock_o,
  output logic [gsh_pkg::ADDR_W-1:0]     host_addr_in_o,
  input  wire logic [gsh_pkg::DATA_W-1:0] host_data_in_i,
  output logic [gsh_pkg::DATA_W-1:0]     host_data_out_o,
  output logic                           host_data_oe_n_o,
  output logic                           dev_select_n_o,
  output logic                           low_byte_write_n_o,
  output logic                           high_byte_write_n_o,
  output logic                           low_byte_read_n_o,
  output logic                           high_byte_read_n_o,
  input  wire logic                      dev_wait_n_i
);
  import gsh_pkg::*;

  localparam int DIV_HALF = 4;

  gsh_state_e              state_q;
  logic [2:0]              div_q;
  logic                    clk_rise;
  logic [7:0]              cnt_q;
  logic                    wait_s1_q;
  logic                    wait_s2_q;
  logic [DATA_W-1:0]       din_s1_q;
  logic [DATA_W-1:0]       din_s2_q;
  logic [ADDR_W-1:0]       addr_q;
  logic [DATA_W-1:0]       wdata_q;
  logic [DATA_W-1:0]       rdata_q;
  logic [4:0]              ctrl_q;
  logic                    busy_q;
  logic                    err_q;
  logic                    done_q;
  logic                    go;
  logic                    aw_hold_q;
  logic                    w_hold_q;
  logic [7:0]              awaddr_q;
  logic [31:0]             wbus_q;
  logic                    lanes_any;
  logic                    req_rst;
  logic                    req_ok;
  logic                    req_bad;
  logic                    seq_launch;
  logic                    seq_finish;
  logic                    seq_close;
  logic                    rst_done;

  // Address inside the 128K window; an empty gap lies between buffer and registers
  function automatic logic addr_legal(input logic [ADDR_W-1:0] a);
    addr_legal = (a < BUF_LIMIT) || (a >= REG_BASE);
  endfunction

  // Bus clock made by a divider from clk_i, free running for the device side
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_q             <= 3'h0;
      host_side_clock_o <= 1'b0;
    end else if (div_q == 3'(DIV_HALF - 1)) begin
      div_q             <= 3'h0;
      host_side_clock_o <= ~host_side_clock_o;
    end else begin
      div_q <= div_q + 3'h1;
    end
  end
  assign clk_rise = (div_q == 3'(DIV_HALF - 1)) && !host_side_clock_o;

  // Wait and read data come from the device domain
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wait_s1_q <= 1'b1;
      wait_s2_q <= 1'b1;
      din_s1_q  <= '0;
      din_s2_q  <= '0;
    end else begin
      wait_s1_q <= dev_wait_n_i;
      wait_s2_q <= wait_s1_q;
      din_s1_q  <= host_data_in_i;
      din_s2_q  <= din_s1_q;
    end
  end

  // AXI write side: address and data taken in either order, response after both
  // Ready flops drop on each handshake and rise again after the write response, so each port comes straight from a register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_hold_q   <= 1'b0;
      w_hold_q    <= 1'b0;
      s_awready_o <= 1'b1;
      s_wready_o  <= 1'b1;
      awaddr_q    <= 8'h00;
      wbus_q     <= 32'h0;
      s_bvalid_o <= 1'b0;
      s_bresp_o  <= RESP_OKAY;
    end else begin
      if (s_awvalid_i && s_awready_o) begin
        aw_hold_q   <= 1'b1;
        s_awready_o <= 1'b0;
        awaddr_q  <= s_awaddr_i;
      end
      if (s_wvalid_i && s_wready_o) begin
        w_hold_q   <= 1'b1;
        s_wready_o <= 1'b0;
        wbus_q   <= s_wdata_i;
      end
      if (aw_hold_q && w_hold_q) begin
        aw_hold_q  <= 1'b0;
        w_hold_q   <= 1'b0;
        s_bvalid_o <= 1'b1;
        s_bresp_o  <= (awaddr_q <= OFF_WDATA) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_bvalid_o && s_bready_i) begin
        s_bvalid_o  <= 1'b0;
        s_awready_o <= 1'b1;
        s_wready_o  <= 1'b1;
      end
    end
  end
  assign go = aw_hold_q && w_hold_q && awaddr_q == OFF_CTRL && wbus_q[CTRL_GO] && !busy_q;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_q  <= 5'h0;
      addr_q  <= '0;
      wdata_q <= '0;
    end else if (aw_hold_q && w_hold_q) begin
      if (awaddr_q == OFF_CTRL && !busy_q) begin
        ctrl_q <= wbus_q[4:0];
      end else if (awaddr_q == OFF_ADDR && !busy_q) begin
        addr_q <= wbus_q[ADDR_W-1:0];
      end else if (awaddr_q == OFF_WDATA && !busy_q) begin
        wdata_q <= wbus_q[DATA_W-1:0];
      end
    end
  end

  // AXI read side
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_arready_o <= 1'b1;
      s_rvalid_o  <= 1'b0;
      s_rdata_o   <= 32'h0;
      s_rresp_o  <= RESP_OKAY;
    end else if (s_arvalid_i && s_arready_o) begin
      s_arready_o <= 1'b0;
      s_rvalid_o  <= 1'b1;
      s_rresp_o   <= RESP_OKAY;
      if (s_araddr_i == OFF_CTRL) begin
        s_rdata_o <= {27'h0, ctrl_q};
      end else if (s_araddr_i == OFF_ADDR) begin
        s_rdata_o <= {15'h0, addr_q};
      end else if (s_araddr_i == OFF_WDATA) begin
        s_rdata_o <= {16'h0, wdata_q};
      end else if (s_araddr_i == OFF_RDATA) begin
        s_rdata_o <= {16'h0, rdata_q};
      end else if (s_araddr_i == OFF_STATUS) begin
        s_rdata_o <= {29'h0, err_q, done_q, busy_q};
      end else if (s_araddr_i == OFF_STRAP) begin
        s_rdata_o <= {27'h0, byte_order_strap_o, bus_phase_strap_n_o,
                      mode_strap_bit2_o, mode_strap_bit1_o, mode_strap_bit0_o};
      end else begin
        s_rdata_o <= 32'h0;
        s_rresp_o <= RESP_SLVERR;
      end
    end else if (s_rvalid_o && s_rready_i) begin
      s_rvalid_o  <= 1'b0;
      s_arready_o <= 1'b1;
    end
  end

  // Straps stay steady; the device samples them as its reset rises
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_strap_bit0_o   <= MODE_GENERIC[0];
      mode_strap_bit1_o   <= MODE_GENERIC[1];
      mode_strap_bit2_o   <= MODE_GENERIC[2];
      bus_phase_strap_n_o <= PHASE_GENERIC;
      byte_order_strap_o  <= ORDER_RST;
    end
  end

  // One-cycle events of the access sequencer; each concern below has its own flop block
  // The reset request is read from the written word, as ctrl_q updates on this same edge
  assign lanes_any  = wbus_q[CTRL_LANE_LO] || wbus_q[CTRL_LANE_HI];
  assign req_rst    = (state_q == GSH_IDLE) && go && wbus_q[CTRL_RESET];
  assign req_ok     = (state_q == GSH_IDLE) && go && !wbus_q[CTRL_RESET] &&
                      addr_legal(addr_q) && lanes_any;
  assign req_bad    = (state_q == GSH_IDLE) && go && !wbus_q[CTRL_RESET] && !req_ok;
  assign seq_launch = (state_q == GSH_SETUP) && clk_rise && (cnt_q == 8'(SETUP_CYC - 1));
  // Ends only on the synced wait release seen while selected
  assign seq_finish = (state_q == GSH_WAIT) && clk_rise && wait_s2_q && !dev_select_n_o;
  assign seq_close  = (state_q == GSH_HOLD) && clk_rise;
  assign rst_done   = (state_q == GSH_RST) && clk_rise && (cnt_q == 8'(HOLD_CYC));

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= GSH_RST;
    end else begin
      case (state_q)
        GSH_RST: begin
          if (rst_done) begin
            state_q <= GSH_IDLE;
          end
        end
        GSH_IDLE: begin
          if (req_rst) begin
            state_q <= GSH_RST;
          end else if (req_ok) begin
            state_q <= GSH_SETUP;
          end
        end
        GSH_SETUP: begin
          if (seq_launch) begin
            state_q <= GSH_WAIT;
          end
        end
        GSH_WAIT: begin
          if (seq_finish) begin
            state_q <= GSH_HOLD;
          end
        end
        GSH_HOLD: begin
          if (seq_close) begin
            state_q <= GSH_IDLE;
          end
        end
        default: state_q <= GSH_IDLE;
      endcase
    end
  end

  // Counts bus clock rises in reset and setup only; wait length is open-ended
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= 8'h0;
    end else if (rst_done || seq_launch || req_ok) begin
      cnt_q <= 8'h0;
    end else if (clk_rise && (state_q == GSH_RST || state_q == GSH_SETUP)) begin
      cnt_q <= cnt_q + 8'h1;
    end
  end

  // Status; a refused request reports at once and never touches the bus
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      busy_q <= 1'b1;
      done_q <= 1'b0;
      err_q  <= 1'b0;
    end else if (req_rst) begin
      busy_q <= 1'b1;
    end else if (req_ok) begin
      busy_q <= 1'b1;
      done_q <= 1'b0;
      err_q  <= 1'b0;
    end else if (req_bad) begin
      done_q <= 1'b1;
      err_q  <= 1'b1;
    end else if (rst_done) begin
      busy_q <= 1'b0;
    end else if (seq_close) begin
      busy_q <= 1'b0;
      done_q <= 1'b1;
    end
  end

  // Straps are held before and after this release edge
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dev_reset_n_o <= 1'b0;
    end else if (req_rst) begin
      dev_reset_n_o <= 1'b0;
    end else if (rst_done) begin
      dev_reset_n_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      host_addr_in_o <= '0;
      dev_select_n_o <= 1'b1;
    end else if (req_ok) begin
      host_addr_in_o <= addr_q;
      dev_select_n_o <= 1'b0;
    end else if (seq_close) begin
      dev_select_n_o <= 1'b1;
    end
  end

  // Write data is driven from the strobe edge through hold and released on the same edge that raises select
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      host_data_out_o  <= '0;
      host_data_oe_n_o <= 1'b1;
    end else if (seq_launch && ctrl_q[CTRL_WRITE]) begin
      host_data_out_o  <= wdata_q;
      host_data_oe_n_o <= 1'b0;
    end else if (seq_close) begin
      host_data_oe_n_o <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      low_byte_write_n_o  <= 1'b1;
      high_byte_write_n_o <= 1'b1;
      low_byte_read_n_o   <= 1'b1;
      high_byte_read_n_o  <= 1'b1;
    end else if (seq_launch) begin
      low_byte_write_n_o  <= !(ctrl_q[CTRL_WRITE] && ctrl_q[CTRL_LANE_LO]);
      high_byte_write_n_o <= !(ctrl_q[CTRL_WRITE] && ctrl_q[CTRL_LANE_HI]);
      low_byte_read_n_o   <= !(!ctrl_q[CTRL_WRITE] && ctrl_q[CTRL_LANE_LO]);
      high_byte_read_n_o  <= !(!ctrl_q[CTRL_WRITE] && ctrl_q[CTRL_LANE_HI]);
    end else if (seq_finish) begin
      low_byte_write_n_o  <= 1'b1;
      high_byte_write_n_o <= 1'b1;
      low_byte_read_n_o   <= 1'b1;
      high_byte_read_n_o  <= 1'b1;
    end
  end

  // Read data has stood for bus clocks before the synced wait releases, so its copy is settled
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_q <= '0;
    end else if (seq_finish && !ctrl_q[CTRL_WRITE]) begin
      rdata_q <= din_s2_q;
    end
  end
endmodule : gsh_host
`default_nettype wire

// [bench/gsh_host_props.sv]
// Port checker for the strobe-port host controller
`timescale 1ns/10ps
`default_nettype none
module gsh_host_props (
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  input wire logic        dev_reset_n_o,
  input wire logic        mode_strap_bit0_o,
  input wire logic        mode_strap_bit1_o,
  input wire logic        mode_strap_bit2_o,
  input wire logic        byte_order_strap_o,
  input wire logic        bus_phase_strap_n_o,
  input wire logic        host_side_clock_o,
  input wire logic [16:0] host_addr_in_o,
  input wire logic        host_data_oe_n_o,
  input wire logic        dev_select_n_o,
  input wire logic        low_byte_write_n_o,
  input wire logic        high_byte_write_n_o,
  input wire logic        low_byte_read_n_o,
  input wire logic        high_byte_read_n_o,
  input wire logic        dev_wait_n_i
);
  import gsh_pkg::*;
  wire wr_hi  = low_byte_write_n_o && high_byte_write_n_o;
  wire rd_hi  = low_byte_read_n_o && high_byte_read_n_o;
  wire all_hi = wr_hi && rd_hi;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_mode;
    $rose(dev_reset_n_o) |-> {mode_strap_bit2_o, mode_strap_bit1_o, mode_strap_bit0_o,
                              bus_phase_strap_n_o} == 4'he;
  endproperty
  a_mode: assert property (p_mode) else $error("mode straps wrong at device reset release");
  property p_order;
    $rose(dev_reset_n_o) |-> $stable(byte_order_strap_o) && !byte_order_strap_o;
  endproperty
  a_order: assert property (p_order) else $error("byte order strap unsettled at release");
  property p_wr_sel;
    !wr_hi |-> !dev_select_n_o && rd_hi;
  endproperty
  a_wr_sel: assert property (p_wr_sel) else $error("write strobe outside select");
  property p_rd_sel;
    !rd_hi |-> !dev_select_n_o && host_data_oe_n_o;
  endproperty
  a_rd_sel: assert property (p_rd_sel) else $error("read strobe with data driven");
  property p_release;
    $rose(all_hi) |-> $past(dev_wait_n_i, 3);
  endproperty
  a_release: assert property (p_release) else $error("strobe released before wait ended");
  property p_window;
    !dev_select_n_o |-> host_addr_in_o < BUF_LIMIT || host_addr_in_o >= REG_BASE;
  endproperty
  a_window: assert property (p_window) else $error("select on unmapped address");
  property p_addr_hold;
    !dev_select_n_o && $past(!dev_select_n_o) |-> $stable(host_addr_in_o);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved under select");
  property p_setup;
    $fell(dev_select_n_o) |-> all_hi[*8];
  endproperty
  a_setup: assert property (p_setup) else $error("strobe too soon after select");
  property p_bclk;
    $rose(host_side_clock_o) |-> ##8 $rose(host_side_clock_o);
  endproperty
  a_bclk: assert property (p_bclk) else $error("bus clock period wrong");
endmodule // gsh_host_props
bind gsh_host gsh_host_props u_props (
  .clk_i(clk_i), .reset_n_i(reset_n_i), .dev_reset_n_o(dev_reset_n_o),
  .mode_strap_bit0_o(mode_strap_bit0_o), .mode_strap_bit1_o(mode_strap_bit1_o),
  .mode_strap_bit2_o(mode_strap_bit2_o), .byte_order_strap_o(byte_order_strap_o),
  .bus_phase_strap_n_o(bus_phase_strap_n_o), .host_side_clock_o(host_side_clock_o),
  .host_addr_in_o(host_addr_in_o), .host_data_oe_n_o(host_data_oe_n_o),
  .dev_select_n_o(dev_select_n_o), .low_byte_write_n_o(low_byte_write_n_o),
  .high_byte_write_n_o(high_byte_write_n_o), .low_byte_read_n_o(low_byte_read_n_o),
  .high_byte_read_n_o(high_byte_read_n_o), .dev_wait_n_i(dev_wait_n_i)
);
`default_nettype wire

// [bench/gsh_dev_model.sv]
// Behavioural model of the display controller behind the strobe port
`timescale 1ns/10ps
`default_nettype none
module gsh_dev_model (
  input  wire logic        host_side_clock_o,
  input  wire logic        dev_reset_n_o,
  input  wire logic        mode_strap_bit0_o,
  input  wire logic        mode_strap_bit1_o,
  input  wire logic        mode_strap_bit2_o,
  input  wire logic        byte_order_strap_o,
  input  wire logic        bus_phase_strap_n_o,
  input  wire logic [16:0] host_addr_in_o,
  input  wire logic [15:0] host_data_out_o,
  input  wire logic        dev_select_n_o,
  input  wire logic        low_byte_write_n_o,
  input  wire logic        high_byte_write_n_o,
  input  wire logic        low_byte_read_n_o,
  input  wire logic        high_byte_read_n_o,
  output logic      [15:0] host_data_in_i,
  output logic             dev_wait_n_i
);
  logic [15:0] mem_q [int];
  logic [15:0] old, last_q = 16'h0;
  logic [4:0]  strap_q = 5'h0;
  logic        rdy_q;
  int          cnt_q, n_acc = 0, n_rst = 0;
  wire rd_act = !(low_byte_read_n_o && high_byte_read_n_o);
  wire wr_act = !(low_byte_write_n_o && high_byte_write_n_o);
  wire [15:0] key = host_addr_in_o[16:1];
  always @(posedge dev_reset_n_o) begin
    strap_q = {mode_strap_bit2_o, mode_strap_bit1_o, mode_strap_bit0_o,
               bus_phase_strap_n_o, byte_order_strap_o};
    n_rst++;
  end
  // Pull-up holds the line high while deselected
  assign dev_wait_n_i = dev_select_n_o ? 1'b1 : rdy_q;
  // Undriven bus shows the inverse of the last word, not a stale copy
  always_comb host_data_in_i = (!dev_select_n_o && rd_act) ? mem_q[key] : ~last_q;
  // Samples on the falling bus clock, half a period clear of the host's launch edge
  always @(negedge host_side_clock_o or negedge dev_reset_n_o) begin
    if (!dev_reset_n_o) begin
      rdy_q <= 1'b0;
      cnt_q <= 0;
    end else if (dev_select_n_o) begin
      rdy_q <= 1'b0;
      // Every fourth access meets a refresh collision
      cnt_q <= (n_acc % 4 == 3) ? 40 : (n_acc * 5) % 11;
    end else if ((rd_act || wr_act) && !rdy_q && strap_q[4:1] == 4'he) begin
      if (cnt_q == 0) begin
        rdy_q <= 1'b1;
        n_acc++;
        old = mem_q.exists(key) ? mem_q[key] : 16'h0;
        if (wr_act)
          mem_q[key] = {high_byte_write_n_o ? old[15:8] : host_data_out_o[15:8],
                        low_byte_write_n_o ? old[7:0] : host_data_out_o[7:0]};
      end else
        cnt_q <= cnt_q - 1;
    end
    if (rd_act && !dev_select_n_o)
      last_q <= host_data_in_i;
  end
endmodule // gsh_dev_model
`default_nettype wire

// [bench/gsh_host_tb_top.sv]
// Self-checking bench for the strobe-port host controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module gsh_host_tb_top;
  import gsh_pkg::*;
  logic clk_i = 0, reset_n_i = 0;
  logic [7:0] s_awaddr_i = 0, s_araddr_i = 0;
  logic [31:0] s_wdata_i = 0, s_rdata_o, st, rd, rnd = 32'hfa417283;
  logic [3:0] s_wstrb_i = 4'hf;
  logic s_awvalid_i = 0, s_wvalid_i = 0, s_bready_i = 0, s_arvalid_i = 0, s_rready_i = 0;
  logic s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o, dev_reset_n_o;
  logic [1:0] s_bresp_o, s_rresp_o, r;
  logic mode_strap_bit0_o, mode_strap_bit1_o, mode_strap_bit2_o, byte_order_strap_o;
  logic bus_phase_strap_n_o, host_side_clock_o, host_data_oe_n_o, dev_select_n_o, dev_wait_n_i;
  logic low_byte_write_n_o, high_byte_write_n_o, low_byte_read_n_o, high_byte_read_n_o;
  logic [16:0] host_addr_in_o, a;
  logic [15:0] host_data_in_i, host_data_out_o, d, e;
  int num_errors = 0, n_checks = 0, n;
  gsh_host uut (
    .clk_i(clk_i), .reset_n_i(reset_n_i),
    .s_awaddr_i(s_awaddr_i), .s_awvalid_i(s_awvalid_i), .s_awready_o(s_awready_o),
    .s_wdata_i(s_wdata_i), .s_wstrb_i(s_wstrb_i),
    .s_wvalid_i(s_wvalid_i), .s_wready_o(s_wready_o),
    .s_bresp_o(s_bresp_o), .s_bvalid_o(s_bvalid_o), .s_bready_i(s_bready_i),
    .s_araddr_i(s_araddr_i), .s_arvalid_i(s_arvalid_i), .s_arready_o(s_arready_o),
    .s_rdata_o(s_rdata_o), .s_rresp_o(s_rresp_o),
    .s_rvalid_o(s_rvalid_o), .s_rready_i(s_rready_i),
    .dev_reset_n_o(dev_reset_n_o), .mode_strap_bit0_o(mode_strap_bit0_o),
    .mode_strap_bit1_o(mode_strap_bit1_o), .mode_strap_bit2_o(mode_strap_bit2_o),
    .byte_order_strap_o(byte_order_strap_o), .bus_phase_strap_n_o(bus_phase_strap_n_o),
    .host_side_clock_o(host_side_clock_o), .host_addr_in_o(host_addr_in_o),
    .host_data_in_i(host_data_in_i), .host_data_out_o(host_data_out_o),
    .host_data_oe_n_o(host_data_oe_n_o), .dev_select_n_o(dev_select_n_o),
    .low_byte_write_n_o(low_byte_write_n_o), .high_byte_write_n_o(high_byte_write_n_o),
    .low_byte_read_n_o(low_byte_read_n_o), .high_byte_read_n_o(high_byte_read_n_o),
    .dev_wait_n_i(dev_wait_n_i)
  );
  gsh_dev_model m (
    .host_side_clock_o(host_side_clock_o), .dev_reset_n_o(dev_reset_n_o),
    .mode_strap_bit0_o(mode_strap_bit0_o), .mode_strap_bit1_o(mode_strap_bit1_o),
    .mode_strap_bit2_o(mode_strap_bit2_o), .byte_order_strap_o(byte_order_strap_o),
    .bus_phase_strap_n_o(bus_phase_strap_n_o), .host_addr_in_o(host_addr_in_o),
    .host_data_out_o(host_data_out_o), .dev_select_n_o(dev_select_n_o),
    .low_byte_write_n_o(low_byte_write_n_o), .high_byte_write_n_o(high_byte_write_n_o),
    .low_byte_read_n_o(low_byte_read_n_o), .high_byte_read_n_o(high_byte_read_n_o),
    .host_data_in_i(host_data_in_i), .dev_wait_n_i(dev_wait_n_i)
  );
  always #5 clk_i = ~clk_i;
  function automatic logic [31:0] xs();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd;
  endfunction
  function automatic logic [15:0] mrg(logic [15:0] o, logic [15:0] v, logic [1:0] ln);
    return {ln[1] ? v[15:8] : o[15:8], ln[0] ? v[7:0] : o[7:0]};
  endfunction
  task automatic axw(input logic [7:0] ad, input logic [31:0] dt, output logic [1:0] rs);
    bit ta = 0, tw = 0;
    @(posedge clk_i);
    s_awaddr_i <= ad; s_awvalid_i <= 1'b1; s_wdata_i <= dt; s_wvalid_i <= 1'b1; s_bready_i <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge clk_i);
      if (s_awready_o) begin ta = 1; s_awvalid_i <= 1'b0; end
      if (s_wready_o) begin tw = 1; s_wvalid_i <= 1'b0; end
    end
    do @(posedge clk_i); while (s_bvalid_o !== 1'b1);
    rs = s_bresp_o;
    s_bready_i <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] ad, output logic [31:0] dt, output logic [1:0] rs);
    @(posedge clk_i);
    s_araddr_i <= ad; s_arvalid_i <= 1'b1; s_rready_i <= 1'b1;
    do @(posedge clk_i); while (s_arready_o !== 1'b1);
    s_arvalid_i <= 1'b0;
    do @(posedge clk_i); while (s_rvalid_o !== 1'b1);
    dt = s_rdata_o; rs = s_rresp_o;
    s_rready_i <= 1'b0;
  endtask
  task automatic idle();
    do axr(OFF_STATUS, st, r); while (st[0] !== 1'b0);
  endtask
  task automatic acc(input bit wr, input logic [1:0] ln, input logic [16:0] ad, input logic [15:0] dt);
    axw(OFF_ADDR, {15'h0, ad}, r);
    axw(OFF_WDATA, {16'h0, dt}, r);
    axw(OFF_CTRL, {28'h0, ln, wr, 1'b1}, r);
    idle();
    axr(OFF_RDATA, rd, r);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // About twenty accesses of up to forty refresh bus clocks each, with a wide margin
  initial begin
    #400000;
    num_errors++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    idle();
    `CHK("straps", 5'b11100, m.strap_q)
    for (int i = 0; i < 7; i++) begin
      a = (i == 0) ? 17'h1fffe : (i == 1) ? BUF_LIMIT - 17'h2 : 17'(xs() % 32'h14000) & 17'h1fffe;
      d = 16'(xs());
      acc(1'b1, 2'b11, a, d);
      `CHK("wr_status", 3'b010, st[2:0])
      acc(1'b0, 2'b11, a, 16'h0);
      `CHK("rd_data", d, rd[15:0])
    end
    for (int ln = 1; ln < 3; ln++) begin
      e = 16'(xs());
      acc(1'b1, 2'(ln), a, e);
      d = mrg(d, e, 2'(ln));
      acc(1'b0, 2'b11, a, 16'h0);
      `CHK("lane_data", d, rd[15:0])
    end
    n = m.n_acc;
    acc(1'b1, 2'b11, BUF_LIMIT, 16'h5a5a);
    `CHK("gap_status", 3'b110, st[2:0])
    acc(1'b1, 2'b00, 17'h0, 16'ha5a5);
    `CHK("nolane_status", 3'b110, st[2:0])
    `CHK("no_cycle", n, m.n_acc)
    axr(8'h18, rd, r);
    `CHK("unmapped_resp", RESP_SLVERR, r)
    axw(OFF_RDATA, 32'h1, r);
    `CHK("ro_resp", RESP_SLVERR, r)
    axw(OFF_CTRL, 32'h11, r);
    idle();
    `CHK("relatch", 2, m.n_rst)
    print_verdict();
  end
endmodule // gsh_host_tb_top
`default_nettype wire
